// *** bench/wake_dev_model.sv ***
// behavioural wake receiver: serial config latch, pattern match, wake pin
`timescale 1ns/1ps
`default_nettype none
module wake_dev_model #(
  parameter int HALF     = 20,
  parameter int ZERO_TOL = 0
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic ser_cs,
  input  wire logic ser_scl,
  input  wire logic ser_sda,
  input  wire logic lf_tx_data,
  input  wire logic lf_tx_active,
  input  wire logic art_wake,
  input  wire logic double_pattern_enable,
  output logic      wake_b
);
  localparam logic [15:0] PAT = 16'h9669;
  logic [7:0]  lat;
  logic [5:0]  pwr, chsel, tst;
  logic        scl_q, cs_q, por, clr_seen, armed;
  logic [15:0] hist;
  int          cnt, det_count, act_cycles, since;
  wire scl_rise = ser_scl & ~scl_q;
  wire cs_fall  = ~ser_cs & cs_q;
  wire take     = lf_tx_active && cnt == HALF / 2;
  wire [15:0] win      = {hist[14:0], lf_tx_data};
  wire [4:0]  zero_err = 5'($countones(win & ~PAT));
  // all one half-bits must match, zero half-bits may miss up to the tolerance
  wire det = take && (win & PAT) == PAT && zero_err <= 5'(ZERO_TOL);
  // second pattern counts only one pattern after the first; each has its own budget
  wire pair     = armed && since == 15;
  wire wake_hit = det && (!double_pattern_enable || pair);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_q, cs_q, lat, hist, clr_seen, armed} <= '0;
      pwr        <= 6'h0f;
      chsel      <= 6'h00;
      tst        <= 6'h10;
      {cnt, det_count, act_cycles, since} <= '0;
      wake_b     <= 1'b1;
      por        <= 1'b1;
    end else begin
      scl_q <= ser_scl;
      cs_q  <= ser_cs;
      por   <= 1'b0;
      if (ser_cs && scl_rise) lat <= {ser_sda, lat[7:1]};
      if (cs_fall) begin
        case (lat[1:0])
          2'h0: pwr <= lat[7:2];
          2'h1: chsel <= lat[7:2];
          2'h2: tst <= lat[7:2];
          default: ;
        endcase
      end
      cnt <= (!lf_tx_active || cnt == HALF - 1) ? 0 : cnt + 1;
      if (take) hist <= {hist[14:0], lf_tx_data};
      if (det) begin
        det_count <= det_count + 1;
        armed     <= !pair;
        since     <= 0;
      end else if (take) begin
        since <= since + 1;
      end
      if (lf_tx_active) act_cycles <= act_cycles + 1;
      if (chsel[5]) clr_seen <= 1'b1;
      if (por) wake_b <= 1'b0;
      else if (chsel[5]) wake_b <= 1'b1;
      else if (wake_hit || art_wake) wake_b <= 1'b0;
    end
  end
endmodule // wake_dev_model
`default_nettype wire

// *** bench/wake_host_ctrl_test.sv ***
// self-checking bench for the wake receiver host controller
`timescale 1ns/1ps
`default_nettype none
module wake_host_ctrl_test;
  localparam int HB = 20;
  logic        ref_clk, rst_b, bus_wr, bus_rd, art_wake, dbl_mode;
  logic [7:0]  bus_addr, w;
  logic [31:0] bus_wdata, bus_rdata, rd;
  logic        ser_cs, ser_scl, ser_sda, wake_b, lf_tx_data, lf_tx_active;
  logic [5:0]  exp_p, exp_c, exp_t, sh;
  int          bad_count, tests_run, seed, npre;

  wake_host_ctrl #(.HALFBIT_CYC(HB), .SCL_HALF_CYC(4)) dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ser_cs(ser_cs),
    .ser_scl(ser_scl), .ser_sda(ser_sda), .wake_b(wake_b), .lf_tx_data(lf_tx_data),
    .lf_tx_active(lf_tx_active));
  wake_dev_model #(.HALF(HB)) dev_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .ser_cs(ser_cs), .ser_scl(ser_scl),
    .ser_sda(ser_sda), .lf_tx_data(lf_tx_data), .lf_tx_active(lf_tx_active),
    .art_wake(art_wake), .double_pattern_enable(dbl_mode), .wake_b(wake_b));

  always #10 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    #1 d = bus_rdata;
  endtask
  // poll a status bit with a bounded count
  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i <= 3000; i++) begin
      rdr(wake_host_pkg::REG_STATUS, rd);
      if (rd[b] === v) return;
    end
    bad_count++;
    $display("FAIL t=%0t status got=%h exp bit %0d=%h", $time, rd, b, v);
    close_out();
  endtask
  task automatic clear_wake;
    wr(wake_host_pkg::REG_CTRL, 32'h4);
    wait_st(wake_host_pkg::ST_CLEARING_POS, 1'b1);
    wait_st(wake_host_pkg::ST_CLEARING_POS, 1'b0);
    wait_st(wake_host_pkg::ST_WAKE_POS, 1'b0);
    check(wake_b, 1'b1);
    check(dev_u.chsel, sh);
    wr(wake_host_pkg::REG_STATUS, 32'h8);
    rdr(wake_host_pkg::REG_STATUS, rd);
    check(rd[3], 1'b0);
  endtask
  task automatic frame(input logic dbl);
    int d0, a0;
    d0   = dev_u.det_count;
    a0   = dev_u.act_cycles;
    npre = 2 * ($unsigned($random(seed)) % 6 + 1);
    wr(wake_host_pkg::REG_PREAMBLE, npre | 1);
    dbl_mode <= dbl;
    rdr(wake_host_pkg::REG_PREAMBLE, rd);
    check(rd, npre);
    wr(wake_host_pkg::REG_CTRL, {30'h0, dbl, 1'b1});
    wait_st(wake_host_pkg::ST_FRAME_POS, 1'b1);
    wait_st(wake_host_pkg::ST_FRAME_POS, 1'b0);
    check(dev_u.det_count - d0, dbl ? 2 : 1);
    check(dev_u.act_cycles - a0, (npre + (dbl ? 32 : 16)) * HB);
    wait_st(wake_host_pkg::ST_WAKE_POS, 1'b1);
    rdr(wake_host_pkg::REG_STATUS, rd);
    check(rd[3], 1'b1);
    clear_wake();
    $display("frame test done double=%0d preamble=%0d", dbl, npre);
  endtask

  initial begin
    {ref_clk, bus_wr, bus_rd, art_wake, dbl_mode, rst_b} = '0;
    bus_addr  = 8'h00;
    bus_wdata = 32'h0;
    seed      = 32'h80ef;
    bad_count = 0;
    tests_run = 0;
    sh        = 6'h00;
    repeat (10) @(posedge ref_clk);
    #1 check({ser_cs, ser_scl, ser_sda, lf_tx_data, lf_tx_active}, 0);
    check(bus_rdata, 32'h0);
    @(posedge ref_clk) rst_b <= 1'b1;
    rdr(wake_host_pkg::REG_PREAMBLE, rd);
    check(rd, 32'h8);
    wait_st(wake_host_pkg::ST_BOOT_POS, 1'b0);
    wait_st(wake_host_pkg::ST_CLEARING_POS, 1'b0);
    wait_st(wake_host_pkg::ST_WAKE_POS, 1'b0);
    check(dev_u.clr_seen, 1'b1);
    check(dev_u.chsel, 6'h00);
    check(wake_b, 1'b1);
    rdr(wake_host_pkg::REG_STATUS, rd);
    check(rd[3], 1'b1);
    wr(wake_host_pkg::REG_STATUS, 32'h8);
    rdr(8'h14, rd);
    check(rd, 32'h0);
    $display("startup and bus test done");
    for (int a = 0; a < 4; a++) begin
      w      = 8'($random(seed));
      w[1:0] = 2'(a);
      if (a == 1) w[7] = 1'b0;
      {exp_p, exp_c, exp_t} = {dev_u.pwr, dev_u.chsel, dev_u.tst};
      case (a)
        0: exp_p = w[7:2];
        1: exp_c = w[7:2];
        2: exp_t = w[7:2];
        default: ;
      endcase
      wr(wake_host_pkg::REG_DEV_WRITE, {24'h0, w});
      wait_st(wake_host_pkg::ST_SER_BUSY_POS, 1'b0);
      repeat (3) @(posedge ref_clk);
      check({dev_u.pwr, dev_u.chsel, dev_u.tst}, {exp_p, exp_c, exp_t});
    end
    $display("serial word test done");
    sh = 6'($random(seed));
    wr(wake_host_pkg::REG_CHSEL, {26'h0, sh});
    sh[5] = 1'b0;
    rdr(wake_host_pkg::REG_CHSEL, rd);
    check(rd, {26'h0, sh});
    frame(1'b0);
    frame(1'b1);
    frame(1'b0);
    @(posedge ref_clk) art_wake <= 1'b1;
    @(posedge ref_clk) art_wake <= 1'b0;
    wait_st(wake_host_pkg::ST_WAKE_POS, 1'b1);
    clear_wake();
    $display("artificial wake test done");
    close_out();
  end
endmodule // wake_host_ctrl_test
`default_nettype wire

// *** core/lf_frame_tx.sv ***
// wake frame half-bit generator: preamble then one or two patterns
`timescale 1ns/1ps
`default_nettype none
module lf_frame_tx #(
  parameter int HALF_CYC = wake_host_pkg::HALFBIT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic       double_pattern_enable,
  input  wire logic [7:0] npre,
  output logic            busy,
  output logic            tx_data,
  output logic            tx_active
);
  localparam logic [15:0] PAT = wake_host_pkg::manchester(wake_host_pkg::PATTERN_SYMBOLS);
  logic [15:0] cnt;
  logic [8:0]  idx, pre, total;
  logic        dbl_q, active;
  wire         tick   = active && (cnt == 16'(HALF_CYC - 1));
  wire         in_pre = (idx < pre);
  wire  [8:0]  pidx   = idx - pre;
  wire         hb     = in_pre ? ~idx[0] : PAT[4'hf - pidx[3:0]]; // [R3] [R4] [R8]

  assign busy = active;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt       <= 16'h0000;
      idx       <= 9'h000;
      pre       <= 9'h000;
      total     <= 9'h000;
      dbl_q     <= 1'b0;
      active    <= 1'b0;
      tx_data   <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      tx_data   <= active & hb;
      tx_active <= active;
      cnt       <= tick || !active ? 16'h0000 : cnt + 16'h0001;
      if (!active && start) begin
        active <= 1'b1;
        idx    <= 9'h000;
        dbl_q  <= double_pattern_enable;
        pre    <= {1'b0, npre[7:1], 1'b0}; // [R8]
        total  <= {1'b0, npre[7:1], 1'b0}
                  + (double_pattern_enable ? 9'h020 : 9'h010); // [R7]
      end else if (tick) begin
        if (idx == total - 9'h001)
          active <= 1'b0;
        else
          idx <= idx + 9'h001; // [R6]
      end
    end
  end

  // checking helpers
  logic        prev_hb;
  logic [4:0]  ones;
  logic [15:0] patsh;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_hb <= 1'b0;
      ones    <= 5'h00;
      patsh   <= 16'h0000;
    end else if (tick) begin
      prev_hb <= hb;
      patsh   <= {patsh[14:0], hb};
      ones    <= (pidx[3:0] == 4'h0) ? {4'h0, hb} : ones + {4'h0, hb};
    end
  end
  wire pat_end = tick && !in_pre && pidx[3:0] == 4'hf;

  a_preamble_alternates: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && in_pre && idx != 9'h000) |-> hb != prev_hb) else $error("preamble not alternating"); // [R8]
  a_manchester_pairs: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && !in_pre && pidx[0]) |-> hb != prev_hb) else $error("half-bit pair not manchester"); // [R3]
  a_pattern_value: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pat_end |-> {patsh[14:0], hb} == PAT) else $error("pattern is not the wake value"); // [R4]
  a_pattern_balanced: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pat_end |-> ones + {4'h0, hb} == wake_host_pkg::PATTERN_ONES) else $error("pattern not balanced"); // [R2]
  a_double_back_to_back: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pat_end && dbl_q && pidx[4] == 1'b0) |=> active && idx == $past(idx) + 9'h001)
    else $error("second pattern not immediate"); // [R6]
  a_pattern_length: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && idx == total - 9'h001) |-> total - pre == (dbl_q ? 9'h020 : 9'h010))
    else $error("frame pattern length wrong"); // [R1]
endmodule // lf_frame_tx
`default_nettype wire

// *** core/ser3_writer.sv ***
// three-wire write-only serial master, lsb first, latched by chip select fall
`timescale 1ns/1ps
`default_nettype none
module ser3_writer #(
  parameter int HALF_CYC = wake_host_pkg::SCL_HALF_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic [7:0] byte_in,
  output logic            busy,
  output logic            cs,
  output logic            scl,
  output logic            sda
);
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_LOW, S_HIGH, S_TAIL} ser_state_t;
  ser_state_t  state;
  logic [15:0] cnt;
  logic [2:0]  bitn;
  logic [7:0]  shreg;
  wire         tick = (cnt == 16'(HALF_CYC - 1));

  assign busy = (state != S_IDLE);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      cnt   <= 16'h0000;
      bitn  <= 3'h0;
      shreg <= 8'h00;
      cs    <= 1'b0;
      scl   <= 1'b0;
      sda   <= 1'b0;
    end else begin
      cnt <= (state == S_IDLE || tick) ? 16'h0000 : cnt + 16'h0001;
      unique case (state)
        S_IDLE: if (start) begin
          state <= S_LEAD;
          shreg <= byte_in;
          cs    <= 1'b1; // [R19]
        end
        S_LEAD: if (tick) begin
          state <= S_LOW;
          sda   <= shreg[0]; // [R20]
        end
        S_LOW: if (tick) begin
          state <= S_HIGH;
          scl   <= 1'b1;
        end
        S_HIGH: if (tick) begin
          scl <= 1'b0;
          if (bitn == 3'h7) begin
            state <= S_TAIL;
            bitn  <= 3'h0;
          end else begin
            state <= S_LOW;
            bitn  <= bitn + 3'h1;
            shreg <= {1'b0, shreg[7:1]};
            sda   <= shreg[1]; // [R20]
          end
        end
        S_TAIL: if (tick) begin
          state <= S_IDLE;
          cs    <= 1'b0; // [R19]
        end
      endcase
    end
  end

  // checking helpers: what a receiver would shift in
  logic [7:0] sent, cap;
  logic [3:0] rises;
  logic       scl_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sent  <= 8'h00;
      cap   <= 8'h00;
      rises <= 4'h0;
      scl_q <= 1'b0;
    end else begin
      scl_q <= scl;
      if (state == S_IDLE && start) begin
        sent  <= byte_in;
        rises <= 4'h0;
      end else if (scl && !scl_q) begin
        cap   <= {sda, cap[7:1]};
        rises <= rises + 4'h1;
      end
    end
  end

  sequence s_cs_drop;
    $fell(cs);
  endsequence
  a_lsb_first_order: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_cs_drop |-> cap == sent) else $error("serial word not sent lsb first"); // [R20]
  a_eight_clock_rises: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_cs_drop |-> rises == 4'h8) else $error("serial word not eight bits"); // [R20]
  a_cs_edge_scl_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(cs) || $fell(cs)) |-> !scl) else $error("chip select moved with clock high"); // [R19]
  a_sda_held_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (scl && $past(scl)) |-> $stable(sda)) else $error("data moved while clock high"); // [R19]
endmodule // ser3_writer
`default_nettype wire

// *** core/wake_host_ctrl.sv ***
// host controller for a three-channel wake receiver: config port, clearing, frames
// How it works
// [R1] the receiver looks for one sixteen half-bit wake pattern per channel
// [R2] our pattern has eight one and eight zero half-bits
// [R3] each symbol is two half-bits: one is high-low, zero is low-high
// [R4] the pattern is symbol value 0x96, most significant symbol first
// [R5] double mode in the receiver needs two detections before wake
// [R6] in double mode the second pattern follows the first with no gap
// [R7] a frame is preamble then pattern, once or twice
// [R8] preamble alternates one-zero, even length, eight recommended
// [R9] receiver detects only with all ones right and zero errors within tolerance
// [R10] receiver zero half-bit tolerance is programmable zero to three
// [R11] receiver ORs the three channel detections onto one wake line
// [R12] in double mode the error limit applies to each pattern alone
// [R13] double detection may use two different channels
// [R14] wake stays low until the clear bit is written high then low
// [R15] artificial wakes need the same clearing
// [R16] after power-up the receiver drives wake low
// [R17] after start-up the host clears wake with the normal sequence
// [R18] receiver strength pin floats while chip select is inactive
// [R19] config port is chip select, serial clock and serial data lines
// [R20] each transfer is eight bits, least significant first
// [R21] low two bits are register address, upper six are data
// [R22] chip select fall copies data into the addressed register
// [R23] receiver half-bit rate is crystal clock over twelve
// [R24] while the clear bit is one, wake is held high
// [R25] an unused address changes no register
// [R26] power-on reset idles correlators, stages and the shift latch
`timescale 1ns/1ps
`default_nettype none
module wake_host_ctrl #(
  parameter int HALFBIT_CYC  = wake_host_pkg::HALFBIT_CYC,
  parameter int SCL_HALF_CYC = wake_host_pkg::SCL_HALF_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic             ser_cs,
  output logic             ser_scl,
  output logic             ser_sda,
  input  wire logic        wake_b,
  output logic             lf_tx_data,
  output logic             lf_tx_active
);
  typedef enum logic [2:0] {
    CLR_IDLE,
    CLR_HIGH,
    CLR_HIGH_WAIT,
    CLR_LOW,
    CLR_LOW_WAIT
  } clr_state_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // register decode
  wire wr_ctrl   = bus_wr && hit(bus_addr, wake_host_pkg::REG_CTRL);
  wire wr_pre    = bus_wr && hit(bus_addr, wake_host_pkg::REG_PREAMBLE);
  wire wr_dev    = bus_wr && hit(bus_addr, wake_host_pkg::REG_DEV_WRITE);
  wire wr_chsel  = bus_wr && hit(bus_addr, wake_host_pkg::REG_CHSEL);
  wire wr_status = bus_wr && hit(bus_addr, wake_host_pkg::REG_STATUS);

  // software state
  logic       double_pattern_enable;
  logic [7:0] npre;
  logic [5:0] chsel_shadow;
  logic       wake_seen;
  logic       boot_pending;
  logic       sw_clear_pending;
  clr_state_t clr_state;

  // wake pin synchroniser
  logic wake_meta;
  logic wake_sync;
  logic wake_prev;
  wire  wake_low  = !wake_sync;
  wire  wake_fall = wake_prev && !wake_sync;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_meta <= 1'b1;
      wake_sync <= 1'b1;
      wake_prev <= 1'b1;
    end else begin
      wake_meta <= wake_b;
      wake_sync <= wake_meta;
      wake_prev <= wake_sync;
    end
  end

  // serial engine hookup
  logic       ser_busy;
  logic       frame_busy;
  wire        clr_idle  = (clr_state == CLR_IDLE);
  wire        clr_go    = clr_idle && !ser_busy
                          && (sw_clear_pending || (boot_pending && wake_low)); // [R17]
  wire        sw_start  = wr_dev && clr_idle && !clr_go && !ser_busy;
  wire        clr_hi    = (clr_state == CLR_HIGH);
  wire        clr_lo    = (clr_state == CLR_LOW);
  wire        ser_start = sw_start || clr_hi || clr_lo;

  // clear words: shadow of the channel select register with the clear bit set or cleared
  wire [5:0] clr_data_hi = chsel_shadow
                           | (6'h01 << wake_host_pkg::WAKE_CLEAR_BIT_POS); // [R24]
  wire [5:0] clr_data_lo = chsel_shadow
                           & ~(6'h01 << wake_host_pkg::WAKE_CLEAR_BIT_POS);
  wire       reg_addr_high = wake_host_pkg::DEV_ADDR_CHSEL[1];
  wire       reg_addr_low  = wake_host_pkg::DEV_ADDR_CHSEL[0];
  wire [7:0] clr_word_hi   = {clr_data_hi, reg_addr_high, reg_addr_low}; // [R21]
  wire [7:0] clr_word_lo   = {clr_data_lo, reg_addr_high, reg_addr_low}; // [R21]
  wire [7:0] ser_byte      = clr_hi ? clr_word_hi
                           : clr_lo ? clr_word_lo
                           : bus_wdata[7:0];

  ser3_writer #(
    .HALF_CYC (SCL_HALF_CYC)
  ) u_ser (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .start    (ser_start),
    .byte_in  (ser_byte),
    .busy     (ser_busy),
    .cs       (ser_cs),
    .scl      (ser_scl),
    .sda      (ser_sda)
  );

  // wake clearing sequence: clear bit high, then low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_state <= CLR_IDLE;
    end else begin
      unique case (clr_state)
        CLR_IDLE:      if (clr_go) clr_state <= CLR_HIGH;
        CLR_HIGH:      clr_state <= CLR_HIGH_WAIT; // [R14]
        CLR_HIGH_WAIT: if (!ser_busy) clr_state <= CLR_LOW;
        CLR_LOW:       clr_state <= CLR_LOW_WAIT; // [R14]
        CLR_LOW_WAIT:  if (!ser_busy) clr_state <= CLR_IDLE;
      endcase
    end
  end

  // pending clear requests; a new request wins over its own consumption
  wire clr_req = wr_ctrl && bus_wdata[wake_host_pkg::CTRL_CLEAR_POS];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_pending     <= 1'b1;
      sw_clear_pending <= 1'b0;
    end else begin
      if (clr_go)
        boot_pending <= 1'b0;
      if (clr_req)
        sw_clear_pending <= 1'b1;
      else if (clr_go)
        sw_clear_pending <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      double_pattern_enable <= 1'b0;
      npre                  <= wake_host_pkg::NPRE_RESET;
      chsel_shadow          <= wake_host_pkg::CHSEL_RESET;
    end else begin
      if (wr_ctrl)
        double_pattern_enable <= bus_wdata[wake_host_pkg::CTRL_DOUBLE_POS];
      if (wr_pre)
        npre <= {bus_wdata[7:1], 1'b0}; // [R8]
      if (wr_chsel)
        chsel_shadow <= bus_wdata[5:0] & ~(6'h01 << wake_host_pkg::WAKE_CLEAR_BIT_POS);
    end
  end

  // sticky wake seen flag, write one to clear, set wins
  wire seen_clr = wr_status && bus_wdata[wake_host_pkg::ST_SEEN_POS];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      wake_seen <= 1'b0;
    else if (wake_fall)
      wake_seen <= 1'b1;
    else if (seen_clr)
      wake_seen <= 1'b0;
  end

  // wake frame transmitter
  wire frame_start = wr_ctrl && bus_wdata[wake_host_pkg::CTRL_SEND_POS] && !frame_busy;

  lf_frame_tx #(
    .HALF_CYC (HALFBIT_CYC)
  ) u_frame (
    .ref_clk               (ref_clk),
    .rst_b                 (rst_b),
    .start                 (frame_start),
    .double_pattern_enable (bus_wdata[wake_host_pkg::CTRL_DOUBLE_POS]), // [R5]
    .npre                  (npre),
    .busy                  (frame_busy),
    .tx_data               (lf_tx_data),
    .tx_active             (lf_tx_active)
  );

  // read back
  wire [31:0] status_word = {26'h0000000,
                             boot_pending,
                             !clr_idle,
                             wake_seen,
                             frame_busy,
                             ser_busy,
                             wake_low};
  wire [31:0] ctrl_word   = {30'h00000000, double_pattern_enable, 1'b0};
  wire [31:0] rd_mux      = hit(bus_addr, wake_host_pkg::REG_CTRL)     ? ctrl_word
                          : hit(bus_addr, wake_host_pkg::REG_PREAMBLE) ? {24'h000000, npre}
                          : hit(bus_addr, wake_host_pkg::REG_CHSEL)    ? {26'h0000000, chsel_shadow}
                          : hit(bus_addr, wake_host_pkg::REG_STATUS)   ? status_word
                          : 32'h00000000;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      bus_rdata <= 32'h00000000;
    else
      bus_rdata <= bus_rd ? rd_mux : 32'h00000000;
  end

  // checking helpers
  logic started_any;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      started_any <= 1'b0;
    else if (ser_start)
      started_any <= 1'b1;
  end

  sequence s_clear_high;
    ser_start && ser_byte[7] && ser_byte[1:0] == wake_host_pkg::DEV_ADDR_CHSEL;
  endsequence
  sequence s_clear_low;
    ser_start && !ser_byte[7] && ser_byte[1:0] == wake_host_pkg::DEV_ADDR_CHSEL;
  endsequence

  a_clear_high_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_clear_high |-> ##[1:200] s_clear_low) else $error("clear bit not returned low"); // [R14]
  // while clearing, every word on the wire must be a clear word for the channel register
  a_clear_no_intruder: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R14]
    (ser_start && !clr_idle) |-> ser_byte[1:0] == wake_host_pkg::DEV_ADDR_CHSEL
                                 && ser_byte[6:2] == chsel_shadow[4:0])
    else $error("foreign write inside clearing");
  a_startup_clear: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R17]
    (clr_go && boot_pending && !started_any) |=> s_clear_high)
    else $error("first transfer is not the wake clear");
  a_boot_wait_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (boot_pending && wake_low && clr_idle && !ser_busy) |-> ##1 clr_hi)
    else $error("startup clear not started"); // [R17]
endmodule // wake_host_ctrl
`default_nettype wire

// *** include/wake_host_pkg.sv ***
// constants shared by the wake-receiver host controller
package wake_host_pkg;
  // timing
  localparam int CLK_HZ           = 50_000_000;
  localparam int CLK_NS           = 20;
  localparam int XTAL_HZ          = 32768;
  localparam int HALFBIT_XTAL_DIV = 12;
  localparam int HALFBIT_CYC      = CLK_HZ / XTAL_HZ * HALFBIT_XTAL_DIV
                                    + (CLK_HZ % XTAL_HZ) * HALFBIT_XTAL_DIV / XTAL_HZ;
  localparam int SCL_HALF_NS      = 80;
  localparam int SCL_HALF_CYC     = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  // wake pattern
  localparam logic [7:0] PATTERN_SYMBOLS = 8'h96;
  localparam logic [4:0] PATTERN_HALF    = 5'h10;
  localparam logic [4:0] PATTERN_ONES    = 5'h08;
  localparam logic [7:0] NPRE_RESET      = 8'h08;
  // device serial word: {data[5:0], reg_addr_high, reg_addr_low}
  localparam logic [1:0] DEV_ADDR_POWER  = 2'h0;
  localparam logic [1:0] DEV_ADDR_CHSEL  = 2'h1;
  localparam logic [1:0] DEV_ADDR_TEST   = 2'h2;
  localparam int         WAKE_CLEAR_BIT_POS = 5;
  localparam logic [5:0] CHSEL_RESET     = 6'h00;
  // own register map
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_PREAMBLE    = 8'h04;
  localparam logic [7:0] REG_DEV_WRITE   = 8'h08;
  localparam logic [7:0] REG_CHSEL       = 8'h0c;
  localparam logic [7:0] REG_STATUS      = 8'h10;
  localparam int CTRL_SEND_POS   = 0;
  localparam int CTRL_DOUBLE_POS = 1;
  localparam int CTRL_CLEAR_POS  = 2;
  localparam int ST_WAKE_POS     = 0;
  localparam int ST_SER_BUSY_POS = 1;
  localparam int ST_FRAME_POS    = 2;
  localparam int ST_SEEN_POS     = 3;
  localparam int ST_CLEARING_POS = 4;
  localparam int ST_BOOT_POS     = 5;

  // manchester: symbol 1 -> half-bits 1,0; msb symbol ends up in bits 15:14
  function automatic logic [15:0] manchester(input logic [7:0] s);
    logic [15:0] h;
    h = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      h[2*i+1] = s[i];
      h[2*i]   = ~s[i];
    end
    return h;
  endfunction
endpackage
